/* File: verilog/tzft_pkg.sv */
// shared constants, types and zone tables for the thermal zone fan throttle block
package tzft_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int I2C_HZ = 100_000;
    // four quarter phases per bus bit
    localparam int QTR_CYCLES = CLK_HZ / (4 * I2C_HZ);
    localparam int POLL_MS = 10;
    localparam int POLL_CYCLES = (CLK_HZ / 1000) * POLL_MS;

    // ----------------------------------------------------------------
    // bus addresses, percent codes, zones
    // ----------------------------------------------------------------
    localparam logic [6:0] SENS_ADDR = 7'h48;
    localparam logic [6:0] FAN_ADDR = 7'h2c;
    localparam logic RD_BIT = 1'b1;
    localparam logic WR_BIT = 1'b0;
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam logic [6:0] PCT_OFF = 7'h00;
    localparam logic [6:0] CHARGE_FAN_PCT = 7'h28;
    localparam logic [3:0] ZONE_COOL = 4'h0;
    localparam logic [3:0] ZONE_STBY = 4'h7;
    localparam logic [3:0] ZONE_HIB = 4'h8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] PH_LOW = 2'h0;
    localparam logic [1:0] PH_RISE = 2'h1;
    localparam logic [1:0] PH_HIGH = 2'h2;
    localparam logic [1:0] PH_FALL = 2'h3;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b000,
        ST_START = 3'b001,
        ST_TX = 3'b010,
        ST_RXACK = 3'b011,
        ST_RX = 3'b100,
        ST_TXACK = 3'b101,
        ST_STOP = 3'b110
    } tzft_state_t;

    // ----------------------------------------------------------------
    // zone table
    // ----------------------------------------------------------------
    function automatic logic signed [7:0] zoneLo(input logic [3:0] z);
        case (z)
            4'h0: zoneLo = 8'sh80; // most negative reading, -128
            4'h1: zoneLo = 8'sd55;
            4'h2: zoneLo = 8'sd61;
            4'h3: zoneLo = 8'sd66;
            4'h4: zoneLo = 8'sd70;
            4'h5: zoneLo = 8'sd77;
            4'h6: zoneLo = 8'sd84;
            default: zoneLo = 8'sd86;
        endcase
    endfunction

    function automatic logic signed [7:0] zoneHi(input logic [3:0] z);
        case (z)
            4'h0: zoneHi = 8'sd60;
            4'h1: zoneHi = 8'sd65;
            4'h2: zoneHi = 8'sd69;
            4'h3: zoneHi = 8'sd73;
            4'h4: zoneHi = 8'sd79;
            4'h5: zoneHi = 8'sd86;
            4'h6: zoneHi = 8'sd88;
            4'h7: zoneHi = 8'sd95;
            default: zoneHi = 8'sd127;
        endcase
    endfunction

    function automatic logic [6:0] zoneFan(input logic [3:0] z);
        case (z)
            4'h1: zoneFan = 7'h28;
            4'h2: zoneFan = 7'h32;
            4'h3: zoneFan = 7'h3c;
            4'h4: zoneFan = 7'h46;
            4'h5: zoneFan = 7'h5a;
            4'h6: zoneFan = 7'h64;
            4'h7: zoneFan = 7'h64;
            default: zoneFan = 7'h00;
        endcase
    endfunction

    function automatic logic [6:0] zoneCpu(input logic [3:0] z);
        case (z)
            4'h5: zoneCpu = 7'h4b;
            4'h6: zoneCpu = 7'h32;
            4'h7: zoneCpu = 7'h32;
            4'h8: zoneCpu = 7'h32;
            default: zoneCpu = 7'h64;
        endcase
    endfunction

endpackage

/* File: verilog/tzft_sync.sv */
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module tzft_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    always_comb
    begin
        meta_d = asyncIn;
        sync_d = meta_q;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            syncOut <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            syncOut <= sync_d;
        end
    end
endmodule

/* File: verilog/tzft_thermal_ctrl.sv */
// thermal zone controller: bus master to sensor and fan, zone tracking, throttle and power requests
// Function
// - controller is master of the two-wire bus, driving fan device and temperature sensor.
// - temperature read from the module sensor is forwarded to the host.
// - while a battery charges the fan is turned on at 40 percent or more in every zone except eight, where it is off.
// - processor throttling only when fan is at full speed and still too hot.
// - each of nine zones has its own low and high threshold, overlapping.
// - zone zero covers -128 to 60, full processor speed, fan off.
// - zones one to four keep full speed, fan 40, 50, 60, 70 percent.
// - zone five runs fan 90 and throttles to 75 only once the fan is at 100; zone six to 50, fan 100.
// - zone seven, 86 to 95, requests standby with fan at 100 percent.
// - zone eight requests hibernation with fan off, else power off.
// - hibernation is requested only when hibernation has been enabled.
`timescale 1ns/1ps
module tzft_thermal_ctrl #(
    parameter int POLL_CYCLES = tzft_pkg::POLL_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic charging,
    input wire logic hibEnable,
    input wire logic [6:0] hostFanPct,
    input wire logic hostFanStb,
    output logic [7:0] tempToHost,
    output logic tempValid,
    output logic [3:0] zone,
    output logic [6:0] fanPct,
    output logic [6:0] cpuPct,
    output logic throttle,
    output logic standbyReq,
    output logic hibernateReq,
    output logic powerOffReq,
    output logic busErr
);
    localparam int QW = $clog2(tzft_pkg::QTR_CYCLES);
    localparam int PW = $clog2(POLL_CYCLES);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [3:0] syncVec;
    logic sclS;
    logic sdaS;
    logic chargeS;
    logic hibEnS;

    tzft_sync #(.WIDTH(4)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .asyncIn({sclIn, sdaIn, charging, hibEnable}),
        .syncOut(syncVec)
    );
    assign {sclS, sdaS, chargeS, hibEnS} = syncVec;

    // ----------------------------------------------------------------
    // bus master
    // ----------------------------------------------------------------
    tzft_pkg::tzft_state_t state_q, state_d;
    logic [QW-1:0] qtrCnt_q, qtrCnt_d;
    logic [PW-1:0] pollCnt_q, pollCnt_d;
    logic [1:0] ph_q, ph_d;
    logic [2:0] bitCnt_q, bitCnt_d;
    logic [7:0] shift_q, shift_d;
    logic txnWr_q, txnWr_d;
    logic dataSent_q, dataSent_d;
    logic ackBad_q, ackBad_d;
    logic sclOe_d, sdaOe_d;
    logic busErr_d;
    logic [7:0] temp_d;
    logic tempValid_d;
    logic tick;
    logic [1:0] phNext;
    logic [7:0] addrByte;
    logic [7:0] fanByte;

    always_comb
    begin
        tick = (qtrCnt_q == QW'(tzft_pkg::QTR_CYCLES - 1));
        phNext = ph_q + 2'h1;
        addrByte = txnWr_q ? {tzft_pkg::FAN_ADDR, tzft_pkg::WR_BIT}
                           : {tzft_pkg::SENS_ADDR, tzft_pkg::RD_BIT};
        fanByte = {1'b0, fanPct};
        state_d = state_q;
        qtrCnt_d = tick ? '0 : qtrCnt_q + QW'(1);
        pollCnt_d = pollCnt_q;
        ph_d = ph_q;
        bitCnt_d = bitCnt_q;
        shift_d = shift_q;
        txnWr_d = txnWr_q;
        dataSent_d = dataSent_q;
        ackBad_d = ackBad_q;
        sclOe_d = sclOe;
        sdaOe_d = sdaOe;
        busErr_d = busErr;
        temp_d = tempToHost;
        tempValid_d = 1'b0;
        if (state_q == tzft_pkg::ST_WAIT)
        begin
            sclOe_d = 1'b0;
            sdaOe_d = 1'b0;
            if (pollCnt_q != PW'(POLL_CYCLES - 1))
                pollCnt_d = pollCnt_q + PW'(1);
            else if (tick)
            begin
                state_d = tzft_pkg::ST_START;
                ph_d = tzft_pkg::PH_LOW;
                txnWr_d = 1'b0;
            end
        end
        // a slave holding the clock low stretches the rise phase, delaying the high phase
        else if (tick && !(phNext == tzft_pkg::PH_HIGH && !sclS))
        begin
            ph_d = phNext;
            if (phNext == tzft_pkg::PH_RISE)
                sclOe_d = 1'b0;
            if (phNext == tzft_pkg::PH_FALL && state_q != tzft_pkg::ST_STOP)
                sclOe_d = 1'b1;
            case (state_q)
                tzft_pkg::ST_START:
                begin
                    // data falls while clock is high: start condition
                    if (phNext == tzft_pkg::PH_RISE)
                        sdaOe_d = 1'b1;
                    if (phNext == tzft_pkg::PH_LOW)
                    begin
                        state_d = tzft_pkg::ST_TX;
                        shift_d = addrByte;
                        bitCnt_d = '0;
                        dataSent_d = 1'b0;
                        sdaOe_d = ~addrByte[7];
                    end
                end
                tzft_pkg::ST_TX:
                begin
                    if (phNext == tzft_pkg::PH_LOW)
                    begin
                        if (bitCnt_q == tzft_pkg::LAST_BIT)
                        begin
                            state_d = tzft_pkg::ST_RXACK;
                            sdaOe_d = 1'b0;
                        end
                        else
                        begin
                            bitCnt_d = bitCnt_q + 3'h1;
                            shift_d = {shift_q[6:0], 1'b0};
                            sdaOe_d = ~shift_q[6];
                        end
                    end
                end
                tzft_pkg::ST_RXACK:
                begin
                    if (phNext == tzft_pkg::PH_HIGH)
                        ackBad_d = sdaS;
                    if (phNext == tzft_pkg::PH_LOW)
                    begin
                        bitCnt_d = '0;
                        if (ackBad_q)
                        begin
                            busErr_d = 1'b1;
                            state_d = tzft_pkg::ST_STOP;
                            sdaOe_d = 1'b1;
                        end
                        else if (!txnWr_q)
                        begin
                            state_d = tzft_pkg::ST_RX;
                            sdaOe_d = 1'b0;
                        end
                        else if (!dataSent_q)
                        begin
                            // fan setting goes out as the data byte
                            state_d = tzft_pkg::ST_TX;
                            shift_d = fanByte;
                            dataSent_d = 1'b1;
                            sdaOe_d = ~fanByte[7];
                        end
                        else
                        begin
                            state_d = tzft_pkg::ST_STOP;
                            sdaOe_d = 1'b1;
                        end
                    end
                end
                tzft_pkg::ST_RX:
                begin
                    if (phNext == tzft_pkg::PH_HIGH)
                        shift_d = {shift_q[6:0], sdaS};
                    if (phNext == tzft_pkg::PH_LOW)
                    begin
                        if (bitCnt_q == tzft_pkg::LAST_BIT)
                        begin
                            state_d = tzft_pkg::ST_TXACK;
                            sdaOe_d = 1'b0;
                            temp_d = shift_q;
                            tempValid_d = 1'b1;
                        end
                        else
                            bitCnt_d = bitCnt_q + 3'h1;
                    end
                end
                tzft_pkg::ST_TXACK:
                begin
                    // single byte read: released data line is the nack
                    if (phNext == tzft_pkg::PH_LOW)
                    begin
                        state_d = tzft_pkg::ST_STOP;
                        sdaOe_d = 1'b1;
                    end
                end
                tzft_pkg::ST_STOP:
                begin
                    if (phNext == tzft_pkg::PH_HIGH)
                        sdaOe_d = 1'b0;
                    if (phNext == tzft_pkg::PH_LOW)
                    begin
                        if (!txnWr_q)
                        begin
                            state_d = tzft_pkg::ST_START;
                            txnWr_d = 1'b1;
                        end
                        else
                        begin
                            state_d = tzft_pkg::ST_WAIT;
                            pollCnt_d = '0;
                            if (!ackBad_q)
                                busErr_d = 1'b0;
                        end
                    end
                end
                default:
                    state_d = tzft_pkg::ST_WAIT;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= tzft_pkg::ST_WAIT;
            qtrCnt_q <= '0;
            pollCnt_q <= '0;
            ph_q <= '0;
            bitCnt_q <= '0;
            shift_q <= '0;
            txnWr_q <= 1'b0;
            dataSent_q <= 1'b0;
            ackBad_q <= 1'b0;
            sclOe <= 1'b0;
            sdaOe <= 1'b0;
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
            busErr <= 1'b0;
            tempToHost <= '0;
            tempValid <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            qtrCnt_q <= qtrCnt_d;
            pollCnt_q <= pollCnt_d;
            ph_q <= ph_d;
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            txnWr_q <= txnWr_d;
            dataSent_q <= dataSent_d;
            ackBad_q <= ackBad_d;
            sclOe <= sclOe_d;
            sdaOe <= sdaOe_d;
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
            busErr <= busErr_d;
            tempToHost <= temp_d;
            tempValid <= tempValid_d;
        end
    end

    // ----------------------------------------------------------------
    // zone tracking and thermal actions
    // ----------------------------------------------------------------
    logic [3:0] zone_d;
    logic [6:0] hostFan_q, hostFan_d;
    logic [6:0] fan_d, cpu_d, cpuZone;
    logic throttle_d, standby_d, hib_d, pwrOff_d;
    logic signed [7:0] tempS;

    always_comb
    begin
        tempS = $signed(tempToHost);
        zone_d = zone;
        // overlapping thresholds give hysteresis, one zone per sample
        if (tempValid)
        begin
            if (zone != tzft_pkg::ZONE_HIB && tempS > tzft_pkg::zoneHi(zone))
                zone_d = zone + 4'h1;
            else if (zone != tzft_pkg::ZONE_COOL && tempS < tzft_pkg::zoneLo(zone))
                zone_d = zone - 4'h1;
        end
        hostFan_d = hostFan_q;
        if (hostFanStb)
            hostFan_d = (hostFanPct > tzft_pkg::PCT_FULL) ? tzft_pkg::PCT_FULL : hostFanPct;
        // the table setting is a floor under the host choice
        fan_d = (hostFan_q > tzft_pkg::zoneFan(zone)) ? hostFan_q : tzft_pkg::zoneFan(zone);
        if (chargeS && fan_d < tzft_pkg::CHARGE_FAN_PCT)
            fan_d = tzft_pkg::CHARGE_FAN_PCT;
        if (zone == tzft_pkg::ZONE_HIB)
            fan_d = tzft_pkg::PCT_OFF;
        cpuZone = tzft_pkg::zoneCpu(zone);
        throttle_d = (cpuZone != tzft_pkg::PCT_FULL) && (fan_d == tzft_pkg::PCT_FULL);
        cpu_d = throttle_d ? cpuZone : tzft_pkg::PCT_FULL;
        standby_d = (zone == tzft_pkg::ZONE_STBY);
        hib_d = (zone == tzft_pkg::ZONE_HIB) && hibEnS;
        pwrOff_d = (zone == tzft_pkg::ZONE_HIB) && !hibEnS;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zone <= tzft_pkg::ZONE_COOL;
            hostFan_q <= tzft_pkg::PCT_OFF;
            fanPct <= tzft_pkg::PCT_OFF;
            cpuPct <= tzft_pkg::PCT_FULL;
            throttle <= 1'b0;
            standbyReq <= 1'b0;
            hibernateReq <= 1'b0;
            powerOffReq <= 1'b0;
        end
        else
        begin
            zone <= zone_d;
            hostFan_q <= hostFan_d;
            fanPct <= fan_d;
            cpuPct <= cpu_d;
            throttle <= throttle_d;
            standbyReq <= standby_d;
            hibernateReq <= hib_d;
            powerOffReq <= pwrOff_d;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence seqStartCond;
        !sdaOe && !sclOe ##1 sdaOe && !sclOe;
    endsequence

    AST_START_ONLY_IN_START: assert property (seqStartCond |-> state_q == tzft_pkg::ST_START)
        else $error("start condition outside start state");
    AST_TEMP_FORWARD: assert property (tempValid |-> tempToHost == $past(shift_q))
        else $error("forwarded temperature differs from received byte");
    AST_CHARGE_FAN: assert property ((chargeS && zone != tzft_pkg::ZONE_HIB)
        |=> fanPct >= tzft_pkg::CHARGE_FAN_PCT)
        else $error("fan below charge level while charging");
    AST_THROTTLE_FULL_FAN: assert property (throttle |-> fanPct == tzft_pkg::PCT_FULL
        && cpuPct != tzft_pkg::PCT_FULL)
        else $error("throttle without full fan");
    AST_LOW_ZONES_FULL_CPU: assert property (zone <= 4'h4 |=> cpuPct == tzft_pkg::PCT_FULL
        && !throttle)
        else $error("cpu throttled in low zone");
    AST_ZONE6_THROTTLE: assert property (zone == 4'h6 |=> cpuPct == 7'h32 && throttle)
        else $error("zone six not throttled to half");
    AST_STANDBY_REQ: assert property (zone == tzft_pkg::ZONE_STBY |=> standbyReq
        && fanPct == tzft_pkg::PCT_FULL)
        else $error("zone seven without standby request");
    AST_ZONE8_ACTION: assert property ((zone == tzft_pkg::ZONE_HIB && !hibEnS)
        |=> powerOffReq && !hibernateReq && fanPct == tzft_pkg::PCT_OFF)
        else $error("zone eight without power off");
    AST_HIB_ENABLED: assert property (hibernateReq |-> $past(hibEnS))
        else $error("hibernation requested while disabled");
    AST_ZONE_STEP: assert property ($changed(zone) |-> $past(tempValid)
        && (zone == $past(zone) + 4'h1 || zone == $past(zone) - 4'h1))
        else $error("zone moved without sample or by more than one");
endmodule

/* File: verification/tzft_i2c_partner.sv */
// behavioural two-wire temperature sensor and fan speed device for the thermal bench
`timescale 1ns/1ps
module tzft_i2c_partner (
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] tempC,
    output logic sdaPull,
    output logic [7:0] fanByte,
    output int fanWrites
);
    int bitCnt;
    int byteNo;
    logic [7:0] shiftQ;
    logic rdData;

    initial
    begin
        sdaPull = 1'b0;
        fanByte = 8'h00;
        fanWrites = 0;
        bitCnt = 0;
        byteNo = 0;
        shiftQ = 8'h00;
        rdData = 1'b0;
    end

    // ----------------------------------------------------------------
    // start condition restarts the byte framing
    // ----------------------------------------------------------------
    always @(negedge sda)
    begin
        if (scl)
        begin
            bitCnt = 0;
            byteNo = 0;
            rdData = 1'b0;
        end
    end

    always @(posedge scl)
    begin
        if (bitCnt == 8)
        begin
            bitCnt = 0;
            if (byteNo == 0)
                rdData = (shiftQ == {tzft_pkg::SENS_ADDR, tzft_pkg::RD_BIT});
            else
                rdData = 1'b0;
            byteNo = byteNo + 1;
        end
        else
        begin
            shiftQ = {shiftQ[6:0], sda};
            bitCnt = bitCnt + 1;
        end
    end

    // ----------------------------------------------------------------
    // data only changes while the clock is low; a released line floats to the pull-up
    // ----------------------------------------------------------------
    always @(negedge scl)
    begin
        if (bitCnt == 8 && !rdData)
        begin
            if (byteNo == 0)
                sdaPull = (shiftQ[7:1] == tzft_pkg::SENS_ADDR) ||
                    (shiftQ[7:1] == tzft_pkg::FAN_ADDR);
            else
            begin
                fanByte = shiftQ;
                fanWrites = fanWrites + 1;
                sdaPull = 1'b1;
            end
        end
        else if (bitCnt < 8 && rdData)
            sdaPull = !tempC[7 - bitCnt];
        else
            sdaPull = 1'b0;
    end
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the thermal zone fan throttle controller
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic charging = 1'b0;
    logic hibEnable = 1'b0;
    logic hostFanStb = 1'b0;
    logic [6:0] hostFanPct = 7'h00;
    logic [7:0] tempC = 8'h64;
    logic sclOut, sclOe, sdaOut, sdaOe, tempValid, throttle, busErr;
    logic standbyReq, hibernateReq, powerOffReq, partnerPull, sclW, sdaW;
    logic [7:0] tempToHost, fanByte;
    logic [3:0] zone;
    logic [6:0] fanPct, cpuPct;
    logic [6:0] fanTbl [0:8] = '{7'h00, 7'h28, 7'h32, 7'h3c, 7'h46, 7'h5a, 7'h64, 7'h64, 7'h00};
    logic [6:0] cpuTbl [0:8] = '{7'h64, 7'h64, 7'h64, 7'h64, 7'h64, 7'h4b, 7'h32, 7'h32, 7'h32};
    int fanWrites;
    int failCount = 0;
    int numChecks = 0;
    int cycles = 0;

    // open-drain lines with pull-ups: any party pulling wins
    assign sclW = sclOe ? sclOut : 1'b1;
    assign sdaW = (sdaOe ? sdaOut : 1'b1) & !partnerPull;

    tzft_thermal_ctrl #(.POLL_CYCLES(100)) tzft_thermal_ctrl_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe),
        .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .charging(charging),
        .hibEnable(hibEnable), .hostFanPct(hostFanPct), .hostFanStb(hostFanStb),
        .tempToHost(tempToHost), .tempValid(tempValid), .zone(zone), .fanPct(fanPct),
        .cpuPct(cpuPct), .throttle(throttle), .standbyReq(standbyReq),
        .hibernateReq(hibernateReq), .powerOffReq(powerOffReq), .busErr(busErr)
    );

    tzft_i2c_partner tzft_i2c_partner_inst (
        .scl(sclW), .sda(sdaW), .tempC(tempC), .sdaPull(partnerPull),
        .fanByte(fanByte), .fanWrites(fanWrites)
    );

    always #25 sys_clk = ~sys_clk;

    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        numChecks++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            failCount++;
        end
    endtask

    task automatic stopTest;
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // nine polls of about 8200 cycles each, plus margin
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 95000)
        begin
            failCount++;
            stopTest;
        end
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic testHost;
        hostFanStb = 1'b1;
        hostFanPct = 7'h3c;
        tick(1);
        hostFanStb = 1'b0;
        tick(1);
        chk("fan from host", 8'h3c, {1'b0, fanPct});
        hostFanStb = 1'b1;
        hostFanPct = 7'h78;
        tick(1);
        hostFanStb = 1'b0;
        tick(1);
        chk("fan clipped", 8'h64, {1'b0, fanPct});
        hostFanStb = 1'b1;
        hostFanPct = 7'h1e;
        tick(1);
        hostFanPct = 7'h00;
        tick(1);
        hostFanStb = 1'b0;
        tick(1);
        chk("fan last strobe wins", 8'h00, {1'b0, fanPct});
    endtask

    task automatic testCharge;
        charging = 1'b1;
        tick(6);
        chk("fan while charging", {1'b0, tzft_pkg::CHARGE_FAN_PCT}, {1'b0, fanPct});
        chk("zone while charging", 8'h00, {4'h0, zone});
        charging = 1'b0;
        tick(6);
        chk("fan after charging", 8'h00, {1'b0, fanPct});
    endtask

    // waits for one sensor poll and judges the zone step and everything derived from it
    task automatic sample(input logic [3:0] z);
        int n;
        int w;
        logic [6:0] expCpu;
        n = 0;
        while (tempValid !== 1'b1 && n < 40000)
        begin
            tick(1);
            n++;
        end
        chk("temperature valid", 8'h01, {7'h00, tempValid});
        chk("temperature to host", tempC, tempToHost);
        w = fanWrites;
        tick(3);
        expCpu = (fanTbl[z] == 7'h64) ? cpuTbl[z] : 7'h64;
        chk("zone", {4'h0, z}, {4'h0, zone});
        chk("fan percent", {1'b0, fanTbl[z]}, {1'b0, fanPct});
        chk("cpu percent", {1'b0, expCpu}, {1'b0, cpuPct});
        chk("throttle", {7'h00, expCpu != 7'h64}, {7'h00, throttle});
        chk("requests", {5'h00, z == 4'h7, z == 4'h8 && hibEnable, z == 4'h8 && !hibEnable},
            {5'h00, standbyReq, hibernateReq, powerOffReq});
        n = 0;
        while (fanWrites == w && n < 20000)
        begin
            tick(1);
            n++;
        end
        chk("fan write seen", 8'h01, {7'h00, fanWrites != w});
        chk("fan byte on bus", {1'b0, fanTbl[z]}, fanByte);
        chk("bus error", 8'h00, {7'h00, busErr});
    endtask

    // in zone five the host raises the fan to full, which lets the throttle in
    task automatic testFullFanThrottle;
        hostFanStb = 1'b1;
        hostFanPct = tzft_pkg::PCT_FULL;
        tick(1);
        hostFanStb = 1'b0;
        tick(2);
        chk("cpu at full fan", 8'h4b, {1'b0, cpuPct});
        chk("throttle at full fan", 8'h01, {7'h00, throttle});
        hostFanStb = 1'b1;
        hostFanPct = 7'h00;
        tick(1);
        hostFanStb = 1'b0;
        tick(2);
        chk("cpu after fan drop", 8'h64, {1'b0, cpuPct});
        chk("throttle after fan drop", 8'h00, {7'h00, throttle});
    endtask

    initial
    begin
        repeat (8) @(posedge sys_clk);
        #5;
        chk("reset zone", 8'h00, {4'h0, zone});
        chk("reset cpu", 8'h64, {1'b0, cpuPct});
        chk("reset clock drive", 8'h00, {7'h00, sclOe});
        rst_n = 1'b1;
        tick(3);
        testHost;
        testCharge;
        for (int z = 1; z <= 5; z++)
            sample(z[3:0]);
        testFullFanThrottle;
        for (int z = 6; z <= 8; z++)
            sample(z[3:0]);
        hibEnable = 1'b1;
        tick(6);
        chk("hibernate request", 8'h01, {7'h00, hibernateReq});
        chk("power off request", 8'h00, {7'h00, powerOffReq});
        tempC = 8'h50;
        sample(4'h7);
        stopTest;
    end
endmodule
